// file: design/scp_regs.svh
// Purpose: register offsets, field positions, reset values and counts of the clock prescaler
// Assumes: included by bare name by every file that needs a constant
// Notes:   the control register index is scaled by four to form its byte address
`ifndef SCP_REGS_SVH
`define SCP_REGS_SVH
`define SCP_CTRL_INDEX     10'h061
`define SCP_CTRL_ADDR      12'h184
`define SCP_UNLOCK_BIT     7
`define SCP_UNLOCK_WORD    8'h80
`define SCP_UNLOCK_CYCLES  3'h4
`define SCP_SEL_RESET_OFF  4'h0
`define SCP_SEL_RESET_FUSE 4'h3
`define SCP_SEL_MAX_STD    4'h8
`define SCP_SEL_UNDIV      4'hF
`define SCP_SHIFT_RES      4'h8
`define SCP_RESP_OKAY      2'h0
`define SCP_RESP_SLVERR    2'h2
`endif

// file: design/scp_pkg.sv
// Purpose: state types of the clock prescaler modules
// Assumes: used only by scoped reference, never imported
// Notes:   each module keeps its state in one of these structs, except the top's pin synchronisers and the divider's gap helper
package scp_pkg;
  // unlock window: cycles left while change is allowed
  typedef struct packed {
    logic [2:0] cnt;
  } scp_unl_st_t;
  // divider: phase counter, active shift and the enable pulse
  typedef struct packed {
    logic [8:0] cnt;
    logic [3:0] shift;
    logic       tick;
  } scp_div_st_t;
  // top: bus slave channels plus the prescale select and the programming block flag
  typedef struct packed {
    logic        awready;
    logic        wready;
    logic        aw_held;
    logic        w_held;
    logic [11:0] awaddr;
    logic [7:0]  wdata;
    logic        wstrb0;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [7:0]  rdata;
    logic [1:0]  rresp;
    logic [3:0]  sel;
    logic        prog_block;
  } scp_top_st_t;
endpackage

// file: design/scp_core_if.sv
// Purpose: carries unlock and divider signals between the prescaler modules
// Assumes: one instance inside the top module
// Notes:   no clocking block; all members are plain same-clock signals
`timescale 1ns/1ps
interface scp_core_if;
  logic       set_req; // clean unlock write taken this cycle
  logic       sel_wr;  // select write taken while unlocked
  logic       unlock;  // change window open
  logic [3:0] code;    // prescale select code
  logic       rc;      // rc oscillator is the source
  logic       tick;    // system clock enable pulse
  logic [3:0] shift;   // active log2 of the divide factor
  modport top (output set_req, sel_wr, code, rc, input unlock, tick, shift);
  modport unl (input set_req, sel_wr, output unlock);
  modport dvd (input code, rc, output tick, shift);
endinterface

// file: design/scp_unlock.sv
// Purpose: times the prescale change window
// Assumes: set_req and sel_wr are never high together
// Notes:   a repeat set inside the window is ignored on purpose
`timescale 1ns/1ps
`include "scp_regs.svh"
module scp_unlock (
  input wire logic aclk,
  input wire logic aresetn,
  scp_core_if.unl  c
);
  scp_pkg::scp_unl_st_t st;      // registered state
  scp_pkg::scp_unl_st_t next_st; // next state

  assign c.unlock = (st.cnt != 3'h0);

  // count down; a select write closes the window at once
  always_comb begin
    next_st = st;
    if (st.cnt != 3'h0) begin
      next_st.cnt = st.cnt - 3'h1;
    end
    if (c.sel_wr) begin
      next_st.cnt = 3'h0;
    end else if (c.set_req && st.cnt == 3'h0) begin
      next_st.cnt = `SCP_UNLOCK_CYCLES; // only a closed window arms
    end
  end

  // state register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  property p_rearm_keeps;
    @(posedge aclk) disable iff (!aresetn)
      (st.cnt > 3'h1 && c.set_req) |=> (st.cnt == $past(st.cnt) - 3'h1);
  endproperty
  a_rearm_keeps: assert property (p_rearm_keeps)
    else $error("unlock window restarted or cleared by rewrite");
endmodule

// file: design/scp_divider.sv
// Purpose: turns the select code into a system clock enable pulse
// Assumes: code and rc are stable flops of the same clock
// Notes:   a new factor is only taken at the end of a full period
`timescale 1ns/1ps
`include "scp_regs.svh"
module scp_divider (
  input wire logic aclk,
  input wire logic aresetn,
  scp_core_if.dvd  c
);
  scp_pkg::scp_div_st_t st;      // registered state
  scp_pkg::scp_div_st_t next_st; // next state
  logic [3:0]           want;    // shift asked for by the code
  logic [9:0]           span;    // cycles per period of active shift
  logic                 term;    // last cycle of the period

  assign c.tick  = st.tick;
  assign c.shift = st.shift;

  // map code to shift; rc source doubles the factor except for code F
  always_comb begin
    if (c.code <= `SCP_SEL_MAX_STD) begin
      want = c.code + {3'h0, c.rc};
    end else if (c.code == `SCP_SEL_UNDIV) begin
      want = 4'h0; // undivided
    end else begin
      want = `SCP_SHIFT_RES + {3'h0, c.rc}; // reserved: slowest
    end
    span = 10'h001 << st.shift;
    term = (st.cnt == 9'(span - 10'h001));
  end

  // switching only at period end keeps any pulse gap at old or new width
  always_comb begin
    next_st      = st;
    next_st.tick = term;
    if (term) begin
      next_st.cnt   = 9'h000;
      next_st.shift = want;
    end else begin
      next_st.cnt = st.cnt + 9'h001;
    end
  end

  // state register; reset starts with the reset code's factor
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st       <= '0;
      st.shift <= want;
    end else begin
      st <= next_st;
    end
  end

  logic [9:0] gap; // helper: cycles since last pulse
  // reset starts at zero: the counter restarts with the phase counter at zero
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      gap <= 10'h000;
    end else if (st.tick) begin
      gap <= 10'h001;
    end else begin
      gap <= gap + 10'h001;
    end
  end

  property p_period;
    @(posedge aclk) disable iff (!aresetn)
      (st.tick && $past(aresetn)) |-> (gap == $past(span));
  endproperty
  a_period: assert property (p_period)
    else $error("enable pulse spacing differs from active factor");
endmodule

// file: design/scp_top.sv
// Purpose: system clock prescaler with its control register on AXI4-Lite
// Assumes: one clock; fuse and rc source come from pins and are synchronised
// Notes:   the divided clock is a one-cycle enable, not a gated clock
//
// Chosen here: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`include "scp_regs.svh"
module scp_top (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [11:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output wire logic        s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output wire logic        s_axi_wready,
  output wire logic [1:0]  s_axi_bresp,
  output wire logic        s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [11:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output wire logic        s_axi_arready,
  output wire logic [31:0] s_axi_rdata,
  output wire logic [1:0]  s_axi_rresp,
  output wire logic        s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        divide_by_eight_fuse,
  input  wire logic        rc_osc_selected,
  output wire logic        sys_clk_en,
  output wire logic [3:0]  sys_div_log2,
  output wire logic        nvm_prog_block
);
  scp_pkg::scp_top_st_t st;      // registered state
  scp_pkg::scp_top_st_t next_st; // next state

  // pin synchronisers; first stages feed only second stages
  logic fuse_s1; // fuse, first stage
  logic fuse_s2; // fuse, safe to use
  logic rc_s1;   // rc select, first stage
  logic rc_s2;   // rc select, safe to use

  // write and read path decode
  logic        aw_take;  // address handshake this cycle
  logic        w_take;   // data handshake this cycle
  logic        aw_have;  // address available now
  logic        w_have;   // data available now
  logic [11:0] addr_eff; // address of the write being done
  logic [7:0]  data_eff; // low data byte of the write
  logic        strb_eff; // lane 0 strobe of the write
  logic        wr_go;    // write completes this cycle
  logic        wr_hit;   // write hits the control register
  logic        wr_reg;   // write touches the register byte
  logic        ar_take;  // read address handshake
  logic        rd_hit;   // read hits the control register

  scp_core_if c ();

  // unlock window timer
  scp_unlock u_unlock (
    .aclk    (aclk),
    .aresetn (aresetn),
    .c       (c)
  );

  // period counter and enable pulse
  scp_divider u_divider (
    .aclk    (aclk),
    .aresetn (aresetn),
    .c       (c)
  );

  // no reset here: the fuse must be seen while reset is still low
  always_ff @(posedge aclk) begin
    fuse_s1 <= divide_by_eight_fuse;
    fuse_s2 <= fuse_s1;
    rc_s1   <= rc_osc_selected;
    rc_s2   <= rc_s1;
  end

  // select and source feed the divider straight from flops
  assign c.code = st.sel;
  assign c.rc   = rc_s2;

  // write channel merge: address and data may arrive in either order
  always_comb begin
    aw_take  = s_axi_awvalid && st.awready;
    w_take   = s_axi_wvalid && st.wready;
    aw_have  = st.aw_held || aw_take;
    w_have   = st.w_held || w_take;
    addr_eff = st.aw_held ? st.awaddr : s_axi_awaddr;
    data_eff = st.w_held ? st.wdata : s_axi_wdata[7:0];
    strb_eff = st.w_held ? st.wstrb0 : s_axi_wstrb[0];
    wr_go    = aw_have && w_have;
    wr_hit   = (addr_eff[11:2] == `SCP_CTRL_INDEX);
    // upper lanes hold only zero bits, so only lane 0 matters
    wr_reg   = wr_go && wr_hit && strb_eff;
    ar_take  = s_axi_arvalid && st.arready;
    rd_hit   = (s_axi_araddr[11:2] == `SCP_CTRL_INDEX);
  end

  // unlock requests toward the window timer
  always_comb begin
    // only an exact 0x80 arms; other bits set leave unlock alone
    c.set_req = wr_reg && (data_eff == `SCP_UNLOCK_WORD);
    // select write counts only with unlock written as zero
    c.sel_wr  = wr_reg && !data_eff[`SCP_UNLOCK_BIT] && c.unlock;
  end

  // bus slave and register next state
  always_comb begin
    next_st = st;
    // write address handshake
    if (aw_take) begin
      next_st.awready = 1'b0;
      next_st.aw_held = !wr_go;
      next_st.awaddr  = s_axi_awaddr;
    end
    // write data handshake
    if (w_take) begin
      next_st.wready = 1'b0;
      next_st.w_held = !wr_go;
      next_st.wdata  = s_axi_wdata[7:0];
      next_st.wstrb0 = s_axi_wstrb[0];
    end
    // both halves present: do the write and answer
    if (wr_go) begin
      next_st.aw_held = 1'b0;
      next_st.w_held  = 1'b0;
      next_st.bvalid  = 1'b1;
      next_st.bresp   = wr_hit ? `SCP_RESP_OKAY : `SCP_RESP_SLVERR;
    end
    // response taken: open both channels again
    if (st.bvalid && s_axi_bready) begin
      next_st.bvalid  = 1'b0;
      next_st.awready = 1'b1;
      next_st.wready  = 1'b1;
    end
    // any code accepted; reserved bits are never stored
    if (c.sel_wr) begin
      next_st.sel = data_eff[3:0];
    end
    // undivided rc clock forbids flash and eeprom programming
    next_st.prog_block = (st.sel == `SCP_SEL_UNDIV) && rc_s2;
    // read address handshake: capture data at once
    if (ar_take) begin
      next_st.arready = 1'b0;
      next_st.rvalid  = 1'b1;
      if (rd_hit) begin
        next_st.rdata = {c.unlock, 3'h0, st.sel};
        next_st.rresp = `SCP_RESP_OKAY;
      end else begin
        next_st.rdata = 8'h00;
        next_st.rresp = `SCP_RESP_SLVERR;
      end
    end
    // read data taken
    if (st.rvalid && s_axi_rready) begin
      next_st.rvalid  = 1'b0;
      next_st.arready = 1'b1;
    end
  end

  // state register; reset select follows the synchronised fuse
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st         <= '0;
      st.awready <= 1'b1;
      st.wready  <= 1'b1;
      st.arready <= 1'b1;
      st.sel     <= fuse_s2 ? `SCP_SEL_RESET_FUSE : `SCP_SEL_RESET_OFF;
    end else begin
      st <= next_st;
    end
  end

  // outputs, all from flops
  assign s_axi_awready  = st.awready;
  assign s_axi_wready   = st.wready;
  assign s_axi_bvalid   = st.bvalid;
  assign s_axi_bresp    = st.bresp;
  assign s_axi_arready  = st.arready;
  assign s_axi_rvalid   = st.rvalid;
  assign s_axi_rdata    = {24'h000000, st.rdata};
  assign s_axi_rresp    = st.rresp;
  // core and peripherals advance only on this pulse
  assign sys_clk_en     = c.tick;
  assign sys_div_log2   = c.shift;
  assign nvm_prog_block = st.prog_block;

  // checks on the register and divider behaviour
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  // a dirty write never opens the window
  property p_dirty_no_unlock;
    (wr_reg && data_eff[`SCP_UNLOCK_BIT] && data_eff[6:0] != 7'h00 && !c.unlock)
      |=> !c.unlock;
  endproperty
  a_dirty_no_unlock: assert property (p_dirty_no_unlock)
    else $error("unlock set by write with other bits nonzero");

  // window closes by itself four cycles after opening
  property p_unlock_timeout;
    $rose(c.unlock) |-> ##4 !c.unlock;
  endproperty
  a_unlock_timeout: assert property (p_unlock_timeout)
    else $error("unlock window lasted more than four cycles");

  // window stays open for four cycles unless select is written
  property p_unlock_hold;
    $rose(c.unlock) ##1 (!c.sel_wr)[*3] |-> c.unlock;
  endproperty
  a_unlock_hold: assert property (p_unlock_hold)
    else $error("unlock window closed early");

  // a select write closes the window on the next cycle
  property p_sel_closes;
    c.sel_wr |=> !c.unlock;
  endproperty
  a_sel_closes: assert property (p_sel_closes)
    else $error("unlock still set after select write");

  // select changes only out of an open window
  property p_sel_guarded;
    $changed(st.sel) |-> $past(c.unlock);
  endproperty
  a_sel_guarded: assert property (p_sel_guarded)
    else $error("select changed without unlock");

  // written code is stored whatever its value
  property p_sel_any;
    c.sel_wr |=> (st.sel == $past(data_eff[3:0]));
  endproperty
  a_sel_any: assert property (p_sel_any)
    else $error("select write not stored as written");

  // reset value follows the fuse; the first two reset edges are skipped
  // because the unreset synchroniser is still filling then
  property p_reset_sel;
    @(posedge aclk) disable iff (1'b0)
      (!aresetn && !$past(aresetn, 2))
        |=> (st.sel == ($past(fuse_s2) ? `SCP_SEL_RESET_FUSE : `SCP_SEL_RESET_OFF));
  endproperty
  a_reset_sel: assert property (p_reset_sel)
    else $error("reset select does not match fuse");

  // a pulse loads shift from code and source of the cycle before
  property p_shift_map;
    (c.tick && $past(st.sel) <= `SCP_SEL_MAX_STD)
      |-> (c.shift == $past(st.sel) + {3'h0, $past(rc_s2)});
  endproperty
  a_shift_map: assert property (p_shift_map)
    else $error("divide factor does not match select code");

  // undivided rc operation raises the programming block
  property p_prog_block;
    (st.sel == `SCP_SEL_UNDIV && rc_s2) |=> nvm_prog_block;
  endproperty
  a_prog_block: assert property (p_prog_block)
    else $error("programming not blocked at undivided rc clock");

  // reserved bits always read zero
  property p_reserved_zero;
    s_axi_rvalid |-> (s_axi_rdata[6:4] == 3'h0);
  endproperty
  a_reserved_zero: assert property (p_reserved_zero)
    else $error("reserved bits read nonzero");

  // a write while locked leaves the select alone
  property p_locked_keeps;
    (wr_reg && !c.unlock) |=> $stable(st.sel);
  endproperty
  a_locked_keeps: assert property (p_locked_keeps)
    else $error("select changed by a locked write");

  // code F gives the undivided clock
  property p_undiv_map;
    (c.tick && $past(st.sel) == `SCP_SEL_UNDIV) |-> (c.shift == 4'h0);
  endproperty
  a_undiv_map: assert property (p_undiv_map)
    else $error("code F does not run undivided");

  // reserved codes fall back to the slowest factor
  property p_reserved_map;
    (c.tick && $past(st.sel) > `SCP_SEL_MAX_STD && $past(st.sel) != `SCP_SEL_UNDIV)
      |-> (c.shift == `SCP_SHIFT_RES + {3'h0, $past(rc_s2)});
  endproperty
  a_reserved_map: assert property (p_reserved_map)
    else $error("reserved code not mapped to slowest factor");

  // main scenarios
  property p_cov_unlock;
    $rose(c.unlock);
  endproperty
  c_cov_unlock: cover property (p_cov_unlock);

  property p_cov_change;
    c.sel_wr ##1 $changed(st.sel);
  endproperty
  c_cov_change: cover property (p_cov_change);

  property p_cov_block;
    $rose(nvm_prog_block);
  endproperty
  c_cov_block: cover property (p_cov_block);

  property p_cov_expire;
    $fell(c.unlock) && !$past(c.sel_wr);
  endproperty
  c_cov_expire: cover property (p_cov_expire);

  property p_cov_slowest;
    c.tick && c.shift == `SCP_SHIFT_RES + 4'h1;
  endproperty
  c_cov_slowest: cover property (p_cov_slowest);
endmodule

// file: tb/scp_top_tb_top.sv
// Purpose: self-checking bench for the clock prescaler top
// Assumes: bready and rready stay high, so each answer is taken at once
// Notes:   the divider loop is the long part, up to one old and three new periods a code
`timescale 1ns/1ps
`include "scp_regs.svh"
module scp_top_tb_top;
  logic        aclk;            // bus and core clock
  logic        aresetn;         // synchronous reset, active low
  logic [11:0] awaddr;          // write address
  logic        awvalid;         // write address valid
  logic        awready;         // write address taken
  logic [31:0] wdata;           // write data word
  logic        wvalid;          // write data valid
  logic        wready;          // write data taken
  logic [1:0]  bresp;           // write answer code
  logic        bvalid;          // write answer valid
  logic [11:0] araddr;          // read address
  logic        arvalid;         // read address valid
  logic        arready;         // read address taken
  logic [31:0] rdata;           // read data word
  logic [1:0]  rresp;           // read answer code
  logic        rvalid;          // read answer valid
  logic        fuse;            // divide-by-eight fuse pin
  logic        rc_sel;          // rc oscillator is source
  logic        clk_en;          // system clock enable pulse
  logic [3:0]  div_log2;        // active log2 of the factor
  logic        prog_block;      // programming blocked flag
  int          bad_count;       // mismatches seen
  int          samples_checked; // comparisons made

  scp_top i_scp_top (
    .aclk                 (aclk),
    .aresetn              (aresetn),
    .s_axi_awaddr         (awaddr),
    .s_axi_awvalid        (awvalid),
    .s_axi_awready        (awready),
    .s_axi_wdata          (wdata),
    .s_axi_wstrb          (4'hF),
    .s_axi_wvalid         (wvalid),
    .s_axi_wready         (wready),
    .s_axi_bresp          (bresp),
    .s_axi_bvalid         (bvalid),
    .s_axi_bready         (1'b1),
    .s_axi_araddr         (araddr),
    .s_axi_arvalid        (arvalid),
    .s_axi_arready        (arready),
    .s_axi_rdata          (rdata),
    .s_axi_rresp          (rresp),
    .s_axi_rvalid         (rvalid),
    .s_axi_rready         (1'b1),
    .divide_by_eight_fuse (fuse),
    .rc_osc_selected      (rc_sel),
    .sys_clk_en           (clk_en),
    .sys_div_log2         (div_log2),
    .nvm_prog_block       (prog_block)
  );

  // 200 MHz clock
  initial begin
    aclk = 1'b0;
    forever #2.5 aclk = ~aclk;
  end

  // one comparison; case inequality so an unknown never matches
  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
    samples_checked++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED at %0t: %s got %0h expected %0h", $time, what, got, exp);
    end
  endtask

  // a bounded wait ran out: count it and stop
  task automatic hang(input string what);
    bad_count++;
    $display("CHECK FAILED at %0t: timeout in %s", $time, what);
    conclude();
  endtask

  // verdict and end of run
  task automatic conclude();
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // one write: address and data offered together, each dropped once taken
  task automatic wr(input logic [11:0] a, input logic [7:0] d, output logic [1:0] r);
    logic aw_done;
    logic w_done;
    int   n;
    aw_done = 1'b0;
    w_done  = 1'b0;
    n       = 0;
    awaddr  <= a;
    wdata   <= {24'h0, d};
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    forever begin
      @(posedge aclk);
      n++;
      if (aw_done && w_done && bvalid === 1'b1) begin
        r = bresp;
        break;
      end
      if (awvalid && awready === 1'b1) begin
        aw_done = 1'b1;
        awvalid <= 1'b0;
      end
      if (wvalid && wready === 1'b1) begin
        w_done = 1'b1;
        wvalid <= 1'b0;
      end
      if (n > 200) hang("write");
    end
  endtask

  // one read: data and code taken at the edge where rvalid is seen
  task automatic rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
    logic taken;
    int   n;
    taken = 1'b0;
    n     = 0;
    araddr  <= a;
    arvalid <= 1'b1;
    forever begin
      @(posedge aclk);
      n++;
      if (taken && rvalid === 1'b1) begin
        d = rdata;
        r = rresp;
        break;
      end
      if (arvalid && arready === 1'b1) begin
        taken = 1'b1;
        arvalid <= 1'b0;
      end
      if (n > 200) hang("read");
    end
  endtask

  // control register write expecting OKAY
  task automatic put(input logic [7:0] d);
    logic [1:0] r;
    wr(`SCP_CTRL_ADDR, d, r);
    check({30'h0, r}, {30'h0, `SCP_RESP_OKAY}, "write code");
  endtask

  // control register read compared against the expected byte
  task automatic expect_reg(input logic [7:0] exp, input string what);
    logic [31:0] d;
    logic [1:0]  r;
    rd(`SCP_CTRL_ADDR, d, r);
    check(d, {24'h0, exp}, what);
    check({30'h0, r}, {30'h0, `SCP_RESP_OKAY}, "read code");
  endtask

  // cycles from the last pulse to the next one
  task automatic next_pulse(output int gap);
    gap = 0;
    do begin
      @(posedge aclk);
      gap++;
      if (gap > 1100) hang("pulse");
    end while (clk_en !== 1'b1);
  endtask

  // reset for eight cycles with the given fuse
  task automatic do_reset(input logic f);
    aresetn <= 1'b0;
    fuse    <= f;
    rc_sel  <= 1'b0;
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
  endtask

  // reset state with the fuse left open
  task automatic t_reset_open();
    int g;
    expect_reg(8'h00, "reset value"); // open fuse value
    check({28'h0, div_log2}, 32'h0, "reset shift"); // undivided
    next_pulse(g);
    next_pulse(g);
    check(g, 1, "undivided spacing"); // enable every cycle
    $display("test reset_open done");
  endtask

  // unlock, then a select write with reserved bits set; this one lands at the last cycle
  task automatic t_unlock();
    put(`SCP_UNLOCK_WORD);
    expect_reg(8'h80, "unlock visible"); // unlock opens
    put(8'h74);
    expect_reg(8'h04, "select taken"); // select lands, unlock drops, reserved zero
    $display("test unlock done");
  endtask

  // writes while locked and a dirty unlock word
  task automatic t_locked();
    put(8'h07);
    expect_reg(8'h04, "locked write"); // ignored while locked
    put(8'h81);
    put(8'h03);
    expect_reg(8'h04, "dirty unlock"); // dirty unlock opens nothing
    $display("test locked done");
  endtask

  // select write after the window has run out
  task automatic t_timeout();
    put(`SCP_UNLOCK_WORD);
    repeat (5) @(posedge aclk);
    put(8'h02);
    expect_reg(8'h04, "late write"); // window closed
    $display("test timeout done");
  endtask

  // repeated unlock neither clears nor extends the window
  task automatic t_rewrite();
    put(`SCP_UNLOCK_WORD);
    put(`SCP_UNLOCK_WORD);
    put(8'h06);
    expect_reg(8'h06, "rewrite keeps"); // not cleared
    put(`SCP_UNLOCK_WORD);
    put(`SCP_UNLOCK_WORD);
    repeat (2) @(posedge aclk);
    put(8'h01);
    expect_reg(8'h06, "rewrite no restart"); // not extended
    $display("test rewrite done");
  endtask

  // an address outside the register
  task automatic t_unmapped();
    logic [31:0] d;
    logic [1:0]  r;
    wr(12'h000, `SCP_UNLOCK_WORD, r);
    check({30'h0, r}, {30'h0, `SCP_RESP_SLVERR}, "unmapped write code");
    rd(12'h000, d, r);
    check(d, 32'h0, "unmapped data");
    check({30'h0, r}, {30'h0, `SCP_RESP_SLVERR}, "unmapped read code");
    expect_reg(8'h06, "unmapped no effect"); // nothing opened
    $display("test unmapped done");
  endtask

  // every code with both sources: factor and spacing
  task automatic t_divide();
    logic [3:0] exp;
    int         n;
    int         g;
    for (int rc = 0; rc < 2; rc++) begin
      rc_sel <= rc[0];
      for (int c = 0; c < 16; c++) begin
        exp = (c == 15) ? 4'h0 : (c > 8) ? 4'h8 + rc[3:0] : c[3:0] + rc[3:0];
        put(`SCP_UNLOCK_WORD);
        put({4'h0, c[3:0]});
        n = 0;
        while (div_log2 !== exp) begin
          @(posedge aclk);
          n++;
          if (n > 1100) hang("divider");
        end
        next_pulse(g);
        next_pulse(g);
        next_pulse(g);
        check(g, 1 << exp, "pulse spacing"); // factor per code
        check({31'h0, prog_block}, {31'h0, rc == 1 && c == 15}, "prog block"); // flag
      end
    end
    $display("test divide done");
  endtask

  // second reset with the fuse programmed
  task automatic t_fuse();
    do_reset(1'b1); // fused start keeps a fast source slowed
    expect_reg(8'h03, "fuse reset"); // divide by eight
    check({28'h0, div_log2}, 32'h3, "fuse shift"); // shift three
    put(`SCP_UNLOCK_WORD);
    put(8'h00);
    expect_reg(8'h00, "write over fuse"); // any value accepted
    $display("test fuse done");
  endtask

  // main sequence
  initial begin
    bad_count       = 0;
    samples_checked = 0;
    aresetn         = 1'b0;
    awaddr          = 12'h000;
    awvalid         = 1'b0;
    wdata           = 32'h0;
    wvalid          = 1'b0;
    araddr          = 12'h000;
    arvalid         = 1'b0;
    fuse            = 1'b0;
    rc_sel          = 1'b0;
    @(posedge aclk);
    do_reset(1'b0);
    t_reset_open();
    t_unlock();
    t_locked();
    t_timeout();
    t_rewrite();
    t_unmapped();
    t_divide();
    t_fuse();
    conclude();
  end
endmodule
